// *** core/ahg_defs.vh ***
// timing counts and widths for the converter read host
// What this block does
// - on done, drive byte select low first
// - next cycle, strobe chip select and output enable
// - each byte read lasts eight clock cycles
// - then byte select high, identical low read
// - variant: write sets select, acknowledge forces wait
// - variant: select released during high byte read
// - start by port write, read status by port
// - ready held off from strobe, decode, cycle
// - done raises request, next read clears it
// - service each request before next conversion ends
// - conversions may start from independent trigger
// - byte mode: high byte first, then low
// - starts at least five microseconds apart, pulsed
`ifndef AHG_DEFS_VH
`define AHG_DEFS_VH

// system clock rate in MHz
`define AHG_CLK_MHZ 50
// longest byte read window, ns
`define AHG_READ_NS 160
// longest time rounds down to whole cycles
`define AHG_READ_CYC ((`AHG_READ_NS * `AHG_CLK_MHZ) / 1000)
// least spacing between two start strobes, us
`define AHG_SPACE_US 5
// least time, exact at this rate
`define AHG_SPACE_CYC (`AHG_SPACE_US * `AHG_CLK_MHZ)
// least width of the start strobe low pulse, ns
`define AHG_SCPW_NS 40
// least time rounds up to whole cycles
`define AHG_SCPW_CYC (((`AHG_SCPW_NS * `AHG_CLK_MHZ) + 999) / 1000)
// width of the timer counters
`define AHG_TMR_W 9
// converter result width
`define AHG_RES_W 12

`endif

// *** core/ahg_host.v ***
// host controller that starts the converter and reads its result
`timescale 1ns/1ns
`include "ahg_defs.vh"
module ahg_host #(
  parameter RES_W = `AHG_RES_W,
  parameter TMR_W = `AHG_TMR_W
) (
  input wire clk_sys,
  input wire resetn,
  input wire ce,
  // user side
  input wire conv_req,
  input wire trig_in,
  input wire async_mode,
  input wire word_mode,
  input wire early_release,
  input wire auto_read,
  input wire dma_ack,
  output reg [RES_W-1:0] result_data,
  output reg result_valid,
  output reg overrun,
  output reg start_refused,
  output wire dma_request_line,
  output wire host_ready,
  output reg memory_acknowledge,
  output wire eoc_status,
  output wire busy,
  // converter pins
  input wire adc_eoc,
  input wire [RES_W-1:0] adc_db,
  output reg convert_start_strobe_n,
  output reg adc_cs_n,
  output reg adc_oe_n,
  output reg high_byte_select_out,
  output reg high_byte_select_oe_n
);
  // read sequencer states
  localparam [2:0] ST_IDLE = 3'h0; // waiting for a request
  localparam [2:0] ST_SEL_HI = 3'h1; // byte select driven low
  localparam [2:0] ST_RD_HI = 3'h2; // high byte window
  localparam [2:0] ST_SEL_LO = 3'h3; // byte select driven high
  localparam [2:0] ST_RD_LO = 3'h4; // low byte window
  localparam [2:0] ST_RD_W = 3'h5; // single full word window

  // counts worked out as integers, then cut to the timer width on purpose
  localparam integer READ_LOAD_I = `AHG_READ_CYC - 1; // last count of a byte window
  localparam integer HI_LAST_I = `AHG_READ_CYC - 2; // one cycle short of the window
  localparam integer SPACE_LOAD_I = `AHG_SPACE_CYC; // start spacing
  localparam integer SCPW_LOAD_I = `AHG_SCPW_CYC; // start pulse width
  localparam [TMR_W-1:0] READ_LOAD = READ_LOAD_I[TMR_W-1:0];
  localparam [TMR_W-1:0] HI_LAST_LOAD = HI_LAST_I[TMR_W-1:0];
  localparam [TMR_W-1:0] SPACE_LOAD = SPACE_LOAD_I[TMR_W-1:0];
  localparam [TMR_W-1:0] SCPW_LOAD = SCPW_LOAD_I[TMR_W-1:0];

  // true for states in which the output enable is strobed
  function is_read;
    input [2:0] st;
    begin
      is_read = (st == ST_RD_HI) || (st == ST_RD_LO) || (st == ST_RD_W);
    end
  endfunction

  // byte select level wanted in a state; high means low byte or idle
  function hbe_level;
    input [2:0] st;
    begin
      hbe_level = !((st == ST_SEL_HI) || (st == ST_RD_HI));
    end
  endfunction

  reg rst_s1_reg; // reset release stage one
  reg rst_s2_reg; // reset release stage two
  wire rst_n; // released reset used everywhere

  // async assert, release through two flops
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_s1_reg <= 1'b0;
      rst_s2_reg <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_s2_reg <= rst_s1_reg;
    end
  end
  assign rst_n = rst_s2_reg;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg eoc_d_reg; // last sampled done level
  reg trig_d_reg; // last sampled trigger level
  reg req_latch_reg; // pending result request
  reg [7:0] hi_byte_reg; // high byte held for assembly
  reg sc_active_reg; // start strobe pulse in progress
  wire read_done; // read window ends this cycle
  wire space_done; // spacing since last start elapsed
  wire pw_done; // start pulse width elapsed
  wire hi_last; // next edge starts the last cycle of the current read window
  wire eoc_rise;
  wire trig_rise;
  wire start_want;
  wire start_go;
  wire read_go;
  wire read_load;
  wire clr_latch;

  // done edge, the converter's end of conversion
  assign eoc_rise = adc_eoc && !eoc_d_reg;
  assign eoc_status = adc_eoc; // port status read
  assign trig_rise = trig_in && !trig_d_reg;

  // start source: independent trigger or a port write
  assign start_want = async_mode ? trig_rise : conv_req;
  // spacing enforced; a held trigger gives one pulse, a held port request repeats once per spacing
  assign start_go = start_want && space_done && !sc_active_reg;

  // request taken by the sequencer or by a dma acknowledge
  assign read_go = req_latch_reg && (auto_read || dma_ack);
  // the first read window clears the latch
  assign clr_latch = (state_reg != ST_RD_HI) && (state_reg != ST_RD_W) &&
                     ((state_next == ST_RD_HI) || (state_next == ST_RD_W));
  assign read_load = is_read(state_next) && (state_next != state_reg);

  assign dma_request_line = req_latch_reg;
  // ready held low during the window, released on its last cycle
  assign host_ready = !is_read(state_reg) || read_done;
  assign busy = (state_reg != ST_IDLE) || sc_active_reg;

  // byte read window timer
  ahg_timer #(.W(TMR_W)) u_read_tmr (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .load(read_load),
    .load_val(READ_LOAD),
    .done(read_done)
  );

  // start spacing timer
  ahg_timer #(.W(TMR_W)) u_space_tmr (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .load(start_go),
    .load_val(SPACE_LOAD),
    .done(space_done)
  );

  // start pulse width timer
  ahg_timer #(.W(TMR_W)) u_pw_tmr (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .load(start_go),
    .load_val(SCPW_LOAD),
    .done(pw_done)
  );

  // last cycle marker, loaded with each window one count short
  // the converter registers its bus, so the select may only move on the last
  // cycle; any earlier and the captured high byte would be the low format
  ahg_timer #(.W(TMR_W)) u_hi_last_tmr (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .ce(ce),
    .load(read_load),
    .load_val(HI_LAST_LOAD),
    .done(hi_last)
  );

  // read sequencer next state
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (read_go) begin
          // full word in one read, else two byte reads
          state_next = word_mode ? ST_RD_W : ST_SEL_HI;
        end
      end
      ST_SEL_HI: begin
        // one cycle of select setup before the strobe
        state_next = ST_RD_HI;
      end
      ST_RD_HI: begin
        if (read_done) begin
          // early release skips the select gap
          state_next = early_release ? ST_RD_LO : ST_SEL_LO;
        end
      end
      ST_SEL_LO: begin
        state_next = ST_RD_LO;
      end
      ST_RD_LO: begin
        if (read_done) begin
          state_next = ST_IDLE;
        end
      end
      ST_RD_W: begin
        if (read_done) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // sequencer, latch and edge history
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      // done idles high, so a low history would fake an edge after reset
      eoc_d_reg <= 1'b1;
      trig_d_reg <= 1'b0;
      req_latch_reg <= 1'b0;
      overrun <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      eoc_d_reg <= adc_eoc;
      trig_d_reg <= trig_in;
      // set wins over the clearing read
      if (eoc_rise) begin
        req_latch_reg <= 1'b1;
      end else if (clr_latch) begin
        req_latch_reg <= 1'b0;
      end
      // a new result while one is still pending would be lost
      overrun <= eoc_rise && req_latch_reg && !clr_latch;
    end
  end

  // converter pins, registered from the next state
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      adc_cs_n <= 1'b1;
      adc_oe_n <= 1'b1;
      high_byte_select_out <= 1'b1;
      high_byte_select_oe_n <= 1'b1;
    end else if (ce) begin
      // decode of the converter address gives both strobes
      adc_cs_n <= !is_read(state_next);
      adc_oe_n <= !is_read(state_next);
      // in early mode the select rises on the last high byte cycle
      if ((state_next == ST_RD_HI) && early_release && (state_reg == ST_RD_HI) &&
          hi_last) begin
        high_byte_select_out <= 1'b1;
      end else begin
        high_byte_select_out <= hbe_level(state_next);
      end
      // word mode leaves the pin as a data bit, so it is not driven
      high_byte_select_oe_n <= word_mode && (state_next == ST_IDLE || state_next == ST_RD_W);
    end
  end

  // start strobe pulse, active low, fixed width
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      convert_start_strobe_n <= 1'b1;
      sc_active_reg <= 1'b0;
      start_refused <= 1'b0;
    end else if (ce) begin
      start_refused <= start_want && !start_go;
      if (start_go) begin
        convert_start_strobe_n <= 1'b0;
        sc_active_reg <= 1'b1;
      end else if (sc_active_reg && pw_done) begin
        // never held low, the converter would run continuously
        convert_start_strobe_n <= 1'b1;
        sc_active_reg <= 1'b0;
      end
    end
  end

  // data capture at the end of each window
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hi_byte_reg <= 8'h00;
      result_data <= {RES_W{1'b0}};
      result_valid <= 1'b0;
      memory_acknowledge <= 1'b0;
    end else if (ce) begin
      result_valid <= 1'b0;
      // acknowledge pulse in the cycle after the wait state of each read window ends
      memory_acknowledge <= is_read(state_reg) && read_done;
      if (is_read(state_reg) && read_done) begin
        case (state_reg)
          ST_RD_HI: begin
            // high byte is on the top eight data lines
            hi_byte_reg <= adc_db[RES_W-1:RES_W-8];
          end
          ST_RD_LO: begin
            // low nibble sits left justified on the same lines
            result_data <= {hi_byte_reg, adc_db[RES_W-1:RES_W-4]};
            result_valid <= 1'b1;
          end
          default: begin
            result_data <= adc_db;
            result_valid <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule

// *** core/ahg_timer.v ***
// down counter used for read windows and start spacing
`timescale 1ns/1ns
module ahg_timer #(
  parameter W = 9
) (
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  input wire load,
  input wire [W-1:0] load_val,
  output wire done
);
  reg [W-1:0] cnt_reg; // remaining cycles
  reg [W-1:0] cnt_next;

  // load wins over counting so a fresh window never inherits an old count
  always @* begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = load_val;
    end else if (cnt_reg != {W{1'b0}}) begin
      cnt_next = cnt_reg - {{(W-1){1'b0}}, 1'b1};
    end
  end

  // state frozen while clock enable is low
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= {W{1'b0}};
    end else if (ce) begin
      cnt_reg <= cnt_next;
    end
  end

  assign done = (cnt_reg == {W{1'b0}}); // idle also reads as done
endmodule

// *** verification/ahg_adc_model.sv ***
// behavioural converter: timed conversion, done flag, byte-wide read port
`timescale 1ns/1ns
module ahg_adc_model #(
  parameter [7:0] CONV = 8'h28
) (
  input wire clk_sys,
  input wire resetn,
  input wire sc_n,
  input wire cs_n,
  input wire oe_n,
  input wire sel,
  input wire sel_oe_n,
  output reg eoc,
  output reg [11:0] db
);
  reg sc_q; // strobe level last cycle
  reg [7:0] cnt_reg; // cycles left in the conversion
  reg [3:0] num_reg; // conversions finished
  reg [11:0] val_reg; // latest result
  // falling strobe starts; done rises when each conversion ends
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sc_q <= 1'b1;
      eoc <= 1'b1;
      cnt_reg <= 8'h00;
      num_reg <= 4'h0;
      val_reg <= 12'h000;
    end else begin
      sc_q <= sc_n;
      if (sc_q && !sc_n) begin
        eoc <= 1'b0;
        cnt_reg <= CONV;
      end else if (!eoc && cnt_reg == 8'h00) begin
        eoc <= 1'b1;
        val_reg <= 12'ha5c ^ {3{num_reg}};
        num_reg <= num_reg + 4'h1;
      end else if (!eoc) begin
        cnt_reg <= cnt_reg - 8'h01;
      end
    end
  end
  // released bus toggles so a stale value never reads as data
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      db <= 12'h000;
    end else if (cs_n || oe_n) begin
      db <= ~db;
    end else if (sel_oe_n) begin
      db <= val_reg;
    end else if (!sel) begin
      db <= {val_reg[11:4], ~db[3:0]};
    end else begin
      db <= {val_reg[3:0], ~db[7:0]};
    end
  end
endmodule

// *** verification/ahg_host_monitor.sv ***
// concurrent checks on the converter read host ports
`timescale 1ns/1ns
module ahg_host_monitor (
  input wire clk_sys,
  input wire resetn,
  input wire adc_eoc,
  input wire convert_start_strobe_n,
  input wire adc_cs_n,
  input wire adc_oe_n,
  input wire high_byte_select_out,
  input wire high_byte_select_oe_n,
  input wire dma_request_line,
  input wire host_ready,
  input wire memory_acknowledge
);
  reg [7:0] gap_reg; // strobe-high cycles since last pulse, saturating
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);
  // starts saturated so the first start after reset is legal
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gap_reg <= 8'hff;
    end else if (!convert_start_strobe_n) begin
      gap_reg <= 8'h00;
    end else if (gap_reg != 8'hff) begin
      gap_reg <= gap_reg + 8'h01;
    end
  end
  sequence strobe_s;
    (!convert_start_strobe_n) [*2] ##1 convert_start_strobe_n;
  endsequence
  sequence wait_s;
    (!host_ready) [*7] ##1 host_ready;
  endsequence
  strobe_width_a: assert property ($fell(convert_start_strobe_n) |=> strobe_s)
    else $error("start strobe width wrong");
  start_gap_a: assert property ($fell(convert_start_strobe_n) |-> gap_reg >= 8'hf7)
    else $error("starts too close");
  req_set_a: assert property ($rose(adc_eoc) |=> dma_request_line)
    else $error("request not raised");
  hi_first_a: assert property ($fell(high_byte_select_out) && !high_byte_select_oe_n
    |=> $fell(adc_cs_n)) else $error("read not after select");
  window_len_a: assert property ($fell(adc_oe_n) |-> wait_s)
    else $error("wait state length wrong");
  ack_after_a: assert property ($rose(host_ready) |=> memory_acknowledge)
    else $error("acknowledge missing");
  latch_clear_a: assert property ($fell(dma_request_line) |-> !adc_cs_n)
    else $error("request cleared outside read");
  lo_select_a: assert property ($rose(high_byte_select_out) && !high_byte_select_oe_n
    |-> ##[0:2] (!adc_cs_n && !host_ready)) else $error("low byte read late");
endmodule
bind ahg_host ahg_host_monitor u_mon (.clk_sys(clk_sys), .resetn(resetn), .adc_eoc(adc_eoc),
  .convert_start_strobe_n(convert_start_strobe_n), .adc_cs_n(adc_cs_n), .adc_oe_n(adc_oe_n),
  .high_byte_select_out(high_byte_select_out), .high_byte_select_oe_n(high_byte_select_oe_n),
  .dma_request_line(dma_request_line), .host_ready(host_ready),
  .memory_acknowledge(memory_acknowledge));

// *** verification/test_ahg_host.sv ***
// self-checking bench for the converter read host
`timescale 1ns/1ns
module test_ahg_host;
  reg clk_sys = 1'b0;
  reg resetn = 1'b0;
  reg conv_req = 1'b0, trig_in = 1'b0, dma_ack = 1'b0;
  reg async_mode = 1'b0, word_mode = 1'b0, early_release = 1'b0, auto_read = 1'b1;
  wire [11:0] result_data, adc_db;
  wire result_valid, overrun, start_refused, dma_request_line, host_ready;
  wire memory_acknowledge, adc_eoc, sc_n, cs_n, oe_n, hbs, hbs_oe_n;
  wire eoc_st, busy;
  reg [8:0] rows [0:3]; // async, word, early, auto, cycles to result (0 skips)
  integer num_errors = 0, comparisons = 0, cycles = 0, k = 0, n, i;
  reg seen;
  always #10 clk_sys = ~clk_sys;
  ahg_host dut (.clk_sys(clk_sys), .resetn(resetn), .ce(1'b1), .conv_req(conv_req),
    .trig_in(trig_in), .async_mode(async_mode), .word_mode(word_mode),
    .early_release(early_release), .auto_read(auto_read), .dma_ack(dma_ack),
    .result_data(result_data), .result_valid(result_valid), .overrun(overrun),
    .start_refused(start_refused), .dma_request_line(dma_request_line),
    .host_ready(host_ready), .memory_acknowledge(memory_acknowledge), .eoc_status(eoc_st),
    .busy(busy), .adc_eoc(adc_eoc), .adc_db(adc_db), .convert_start_strobe_n(sc_n),
    .adc_cs_n(cs_n), .adc_oe_n(oe_n), .high_byte_select_out(hbs),
    .high_byte_select_oe_n(hbs_oe_n));
  ahg_adc_model u_adc (.clk_sys(clk_sys), .resetn(resetn), .sc_n(sc_n), .cs_n(cs_n),
    .oe_n(oe_n), .sel(hbs), .sel_oe_n(hbs_oe_n), .eoc(adc_eoc), .db(adc_db));
  task tick;
    begin
      @(posedge clk_sys);
      #1;
    end
  endtask
  task check(input [11:0] got, input [11:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task check_bit(input got, input exp);
    check({11'h000, got}, {11'h000, exp});
  endtask
  // one-cycle start request from the selected source
  task start;
    begin
      if (async_mode) trig_in = 1'b1;
      else conv_req = 1'b1;
      tick;
      trig_in = 1'b0;
      conv_req = 1'b0;
    end
  endtask
  task wait_latch;
    begin
      n = 0;
      while (dma_request_line !== 1'b1 && n < 200) begin
        tick;
        n = n + 1;
      end
      check_bit(dma_request_line, 1'b1);
    end
  endtask
  // read via auto or acknowledge; expected value mirrors the converter sequence
  task read_out(input [4:0] lat);
    begin
      dma_ack = !auto_read;
      n = 0;
      while (result_valid !== 1'b1 && n < 40) begin
        tick;
        n = n + 1;
      end
      dma_ack = 1'b0;
      check(result_data, 12'ha5c ^ {3{k[3:0]}});
      check_bit(memory_acknowledge, 1'b1);
      check_bit(dma_request_line, 1'b0);
      if (lat != 5'h00) check(n[11:0], {7'h00, lat});
      k = k + 1;
    end
  endtask
  task do_reset;
    begin
      resetn = 1'b0;
      repeat (2) tick;
      check({7'h00, sc_n, cs_n, oe_n, hbs, hbs_oe_n}, 12'h01f);
      check(result_data, 12'h000);
      check_bit(dma_request_line, 1'b0);
      resetn = 1'b1;
      repeat (3) tick;
    end
  endtask
  task report_and_stop;
    begin
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  // hang guard, well above the expected run length
  always @(posedge clk_sys) begin
    cycles = cycles + 1;
    if (cycles == 6000) begin
      num_errors = num_errors + 1;
      $display("ERROR %0t timeout", $time);
      report_and_stop;
    end
  end
  initial begin
    rows[0] = 9'h033;
    rows[1] = 9'h0a9;
    rows[2] = 9'h160;
    rows[3] = 9'h189;
    do_reset;
    for (i = 0; i < 4; i = i + 1) begin
      {async_mode, word_mode, early_release, auto_read} = rows[i][8:5];
      tick;
      start;
      wait_latch;
      read_out(rows[i][4:0]);
      repeat (260) tick;
    end
    // second start lands inside the strobe pulse and must be dropped
    {async_mode, word_mode, early_release, auto_read} = 4'h0;
    start;
    tick;
    start;
    seen = start_refused;
    check_bit(busy, 1'b1);
    check_bit(eoc_st, 1'b0);
    repeat (2) begin
      tick;
      seen = seen | start_refused;
    end
    check_bit(seen, 1'b1);
    wait_latch;
    check_bit(eoc_st, 1'b1);
    check_bit(busy, 1'b0);
    repeat (260) tick;
    start;
    k = k + 1; // unread result is overwritten
    seen = 1'b0;
    n = 0;
    while (!seen && n < 200) begin
      tick;
      seen = (overrun === 1'b1);
      n = n + 1;
    end
    check_bit(seen, 1'b1);
    read_out(5'h13);
    repeat (260) tick;
    start;
    wait_latch;
    do_reset; // pending request dropped by reset
    report_and_stop;
  end
endmodule
